// ===== rtl/bpd_pkg.sv
// constants and types for the bus port decode, interrupt route and wait block
// ****************************************
// What this block does
// - The board answers a block of six consecutive I/O ports starting on an eight-port boundary.
// - Address bits 7..3 are compared with a five-bit base setting, so the base is setting times 8.
// - The three lowest positions of the base switch are ignored in decoding.
// - The interrupt request goes to exactly one chosen line: one of eight vectored lines or INT.
// - When routing is set to unused no bus interrupt line is driven.
// - With wait enabled, wait is requested on every access to the disk controller chip, else never.
// - The number of wait states grows with the bus clock rate.
// ****************************************
package bpd_pkg;
  localparam int ADDR_W = 8;
  localparam int BASE_W = 5;
  localparam int BASE_LSB = 3;
  localparam logic [2:0] PORT_SPAN = 3'h6;
  localparam logic [2:0] FDC_FIRST = 3'h0;
  localparam logic [2:0] FDC_LAST = 3'h3;
  localparam int VI_N = 8;
  localparam int ROUTE_W = 4;
  localparam logic [3:0] ROUTE_INT = 4'h8;
  localparam logic [3:0] ROUTE_NONE = 4'hF;
  localparam int WAIT_W = 5;
  localparam int WAIT_NS = 250;
  localparam int CLK_NS = 25;
  localparam int WAIT_CYC = (WAIT_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_HOLD} bpd_state_type;
endpackage : bpd_pkg

// ===== rtl/bpd_wait_gen.sv
// wait-state counter for accesses to the disk controller chip
`timescale 1ns/1ps
module bpd_wait_gen
  import bpd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic cycle_end,
  input wire logic [bpd_pkg::WAIT_W-1:0] count,
  output logic busy
);
  import bpd_pkg::*;
  bpd_state_type state_reg, state_next;
  logic [WAIT_W-1:0] cnt_reg, cnt_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start && count != '0) begin
          state_next = ST_WAIT;
          cnt_next = count;
        end else if (start) begin
          state_next = ST_HOLD;
        end
      end
      ST_WAIT: begin
        cnt_next = cnt_reg - 1'b1;
        // a cut bus cycle drops the request instead of leaving it stuck high
        if (cycle_end) begin
          state_next = ST_IDLE;
        end else if (cnt_reg == WAIT_W'(1)) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cycle_end) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // start cycle asks for wait at once, one cycle on top of the loaded count
  assign busy = (state_reg == ST_IDLE) ? (start && count != '0) : (state_reg == ST_WAIT);
endmodule : bpd_wait_gen

// ===== rtl/bpd_top.sv
// bus slave: port decode, interrupt routing and wait-state request
`timescale 1ns/1ps
module bpd_top
  import bpd_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [bpd_pkg::ADDR_W-1:0] ADDR,
  input wire logic SINP,
  input wire logic SOUT,
  input wire logic CYCLE_ACTIVE,
  input wire logic [bpd_pkg::ADDR_W-1:0] BASE_SW,
  input wire logic [bpd_pkg::ROUTE_W-1:0] IRQ_ROUTE,
  input wire logic WAIT_EN,
  input wire logic [1:0] CPU_SPEED,
  input wire logic IRQ_IN,
  output logic [bpd_pkg::VI_N-1:0] VI_REQ,
  output logic INT_REQ,
  output logic PORT_SEL,
  output logic [2:0] PORT_OFS,
  output logic FDC_SEL,
  output logic RDY_HOLD
);
  import bpd_pkg::*;

  // ****************************************
  // port decode
  // ****************************************
  function automatic logic base_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] sw);
    base_hit = (a[ADDR_W-1:BASE_LSB] == sw[ADDR_W-1:BASE_LSB]);
  endfunction : base_hit

  wire logic io_cycle = CYCLE_ACTIVE && (SINP || SOUT);
  wire logic [2:0] low_ofs = ADDR[BASE_LSB-1:0];
  wire logic in_block = base_hit(ADDR, BASE_SW) && (low_ofs < PORT_SPAN);
  wire logic hit = io_cycle && in_block;
  wire logic fdc_hit = hit && (low_ofs >= FDC_FIRST) && (low_ofs <= FDC_LAST);

  // ****************************************
  // decode registers
  // ****************************************
  // outputs lag the bus by one cycle, so the card side sees settled levels
  logic cyc_d_reg;
  logic [2:0] ofs_reg;
  logic sel_reg;
  logic fdc_reg;
  wire logic [2:0] ofs_next = hit ? low_ofs : '0;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cyc_d_reg <= 1'b0;
    end else begin
      cyc_d_reg <= CYCLE_ACTIVE;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ofs_reg <= '0;
    end else begin
      ofs_reg <= ofs_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sel_reg <= 1'b0;
    end else begin
      sel_reg <= hit;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      fdc_reg <= 1'b0;
    end else begin
      fdc_reg <= fdc_hit;
    end
  end

  assign PORT_SEL = sel_reg;
  assign PORT_OFS = ofs_reg;
  assign FDC_SEL = fdc_reg;

  // ****************************************
  // interrupt routing
  // ****************************************
  // route codes 0..7 pick a vectored line, 8 is INT, anything else is unused
  // one compare per line: a code outside 0..7 leaves every pick bit low
  logic [VI_N-1:0] vi_pick;
  for (genvar i = 0; i < VI_N; i++) begin : g_vi_pick
    assign vi_pick[i] = (IRQ_ROUTE == ROUTE_W'(i));
  end
  wire logic [VI_N-1:0] vi_next = IRQ_IN ? vi_pick : '0;
  wire logic int_next = IRQ_IN && (IRQ_ROUTE == ROUTE_INT);
  logic [VI_N-1:0] vi_reg;
  logic int_reg;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      vi_reg <= '0;
    end else begin
      vi_reg <= vi_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      int_reg <= 1'b0;
    end else begin
      int_reg <= int_next;
    end
  end
  assign VI_REQ = vi_reg;
  assign INT_REQ = int_reg;

  // ****************************************
  // wait states
  // ****************************************
  // faster CPU setting gives more waits; base count fixed by the controller chip access time
  wire logic [WAIT_W-1:0] wait_cnt = WAIT_W'(WAIT_CYC) + WAIT_W'({CPU_SPEED, 1'b0});
  wire logic fdc_start = fdc_hit && WAIT_EN && !fdc_reg;
  wire logic cyc_end = !CYCLE_ACTIVE;
  logic wait_busy;

  bpd_wait_gen u_wait (
    .clk(CLK_SYS),
    .rst(RST),
    .start(fdc_start),
    .cycle_end(cyc_end),
    .count(wait_cnt),
    .busy(wait_busy)
  );
  assign RDY_HOLD = wait_busy && WAIT_EN;

  // ****************************************
  // checks
  // ****************************************
  AST_ONEHOT_ROUTE: assert property (@(posedge CLK_SYS) disable iff (RST)
    $onehot0({vi_reg, int_reg}))
    else $error("more than one interrupt line driven");
  AST_NONE_ROUTE: assert property (@(posedge CLK_SYS) disable iff (RST)
    $past(IRQ_ROUTE) == ROUTE_NONE |-> (vi_reg == '0 && !int_reg))
    else $error("unused route drove a line");
  AST_VI_FOLLOW: assert property (@(posedge CLK_SYS) disable iff (RST)
    (IRQ_IN && IRQ_ROUTE == 4'h3) |=> VI_REQ[3])
    else $error("vectored line not driven");
  AST_NO_MEM: assert property (@(posedge CLK_SYS) disable iff (RST)
    (!SINP && !SOUT) |=> !PORT_SEL)
    else $error("decode outside io cycle");
  AST_SPAN: assert property (@(posedge CLK_SYS) disable iff (RST)
    PORT_SEL |-> PORT_OFS < PORT_SPAN)
    else $error("offset beyond block");
  AST_BASE: assert property (@(posedge CLK_SYS) disable iff (RST)
    PORT_SEL |-> $past(ADDR[ADDR_W-1:BASE_LSB]) == $past(BASE_SW[ADDR_W-1:BASE_LSB]))
    else $error("base mismatch");
  AST_LOW_IGNORED: assert property (@(posedge CLK_SYS) disable iff (RST)
    (io_cycle && ADDR == {BASE_SW[ADDR_W-1:BASE_LSB], 3'h1}) |=> PORT_SEL)
    else $error("low switch bits affected decode");
  AST_WAIT_OFF: assert property (@(posedge CLK_SYS) disable iff (RST)
    !WAIT_EN |-> !RDY_HOLD)
    else $error("wait while disabled");
  AST_WAIT_ON: assert property (@(posedge CLK_SYS) disable iff (RST)
    (fdc_start && CPU_SPEED == 2'h0) |-> RDY_HOLD [*8] ##1 (RDY_HOLD || !WAIT_EN) [*2])
    else $error("wait count too short");

  // ****************************************
  // more decode checks
  // ****************************************
  AST_LAST_PORT: assert property (@(posedge CLK_SYS) disable iff (RST)
    (io_cycle && ADDR == {BASE_SW[ADDR_W-1:BASE_LSB], PORT_SPAN - 3'h1})
    |=> (PORT_SEL && PORT_OFS == PORT_SPAN - 3'h1))
    else $error("last port of the block not decoded");
  AST_PAST_SPAN: assert property (@(posedge CLK_SYS) disable iff (RST)
    (io_cycle && ADDR == {BASE_SW[ADDR_W-1:BASE_LSB], PORT_SPAN}) |=> !PORT_SEL)
    else $error("port beyond the block decoded");
  AST_OFS_IDLE: assert property (@(posedge CLK_SYS) disable iff (RST)
    !PORT_SEL |-> PORT_OFS == '0)
    else $error("offset shown without a hit");
  AST_NO_CYCLE: assert property (@(posedge CLK_SYS) disable iff (RST)
    !CYCLE_ACTIVE |=> !PORT_SEL)
    else $error("decode without a bus cycle");
  AST_OUT_CYCLE: assert property (@(posedge CLK_SYS) disable iff (RST)
    (SOUT && CYCLE_ACTIVE && ADDR == {BASE_SW[ADDR_W-1:BASE_LSB], FDC_LAST}) |=> PORT_SEL)
    else $error("output cycle not decoded");
  AST_FIRST_PORT: assert property (@(posedge CLK_SYS) disable iff (RST)
    (io_cycle && ADDR == {BASE_SW[ADDR_W-1:BASE_LSB], FDC_FIRST}) |=> (PORT_SEL && FDC_SEL))
    else $error("controller chip port not decoded");
  AST_FDC_RANGE: assert property (@(posedge CLK_SYS) disable iff (RST)
    FDC_SEL |-> (PORT_SEL && PORT_OFS <= FDC_LAST))
    else $error("chip select outside the chip ports");

  // ****************************************
  // more interrupt checks
  // ****************************************
  AST_INT_FOLLOW: assert property (@(posedge CLK_SYS) disable iff (RST)
    (IRQ_IN && IRQ_ROUTE == ROUTE_INT) |=> (INT_REQ && VI_REQ == '0))
    else $error("plain interrupt line not driven alone");
  AST_IRQ_QUIET: assert property (@(posedge CLK_SYS) disable iff (RST)
    !IRQ_IN |=> (VI_REQ == '0 && !INT_REQ))
    else $error("interrupt line driven with no request");

  // ****************************************
  // more wait checks
  // ****************************************
  // length of the current wait run, for the count check below
  logic [WAIT_W:0] run_reg;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      run_reg <= '0;
    end else begin
      run_reg <= RDY_HOLD ? run_reg + 1'b1 : '0;
    end
  end
  AST_WAIT_LEN: assert property (@(posedge CLK_SYS) disable iff (RST)
    ($fell(RDY_HOLD) && CYCLE_ACTIVE && cyc_d_reg)
    |-> run_reg == (WAIT_W + 1)'(WAIT_CYC + 1 + 2 * CPU_SPEED))
    else $error("wait run length does not match the speed setting");
  AST_WAIT_IDLE: assert property (@(posedge CLK_SYS) disable iff (RST)
    (!CYCLE_ACTIVE && !cyc_d_reg) |-> !RDY_HOLD)
    else $error("wait asked with no bus cycle");
  AST_WAIT_FDC_ONLY: assert property (@(posedge CLK_SYS) disable iff (RST)
    RDY_HOLD |-> (fdc_hit || FDC_SEL))
    else $error("wait asked outside a chip access");
endmodule : bpd_top

// ===== dv/bpd_cpu_model.sv
// bus master model running I/O and memory cycles
`timescale 1ns/1ps
module bpd_cpu_model (
  input wire logic clk,
  input wire logic rdy,
  output logic [7:0] addr,
  output logic sinp,
  output logic sout,
  output logic cyc
);
  initial begin
    addr = 8'hFF;
    {sinp, sout, cyc} = 3'h0;
  end
  // stretches the cycle while wait is asked, returns how many cycles
  task automatic io(input logic [7:0] a, input logic wr, input logic st, output int waits);
    @(negedge clk);
    addr = a;
    sinp = st & !wr;
    sout = st & wr;
    cyc = 1'h1;
    waits = 0;
    #1;
    while (rdy === 1'h1 && waits < 64) begin
      waits++;
      @(negedge clk);
      #1;
    end
    @(negedge clk);
    // released bus shows inverted lines, not the stale address
    addr = ~a;
    {sinp, sout, cyc} = 3'h0;
  endtask : io
endmodule : bpd_cpu_model

// ===== dv/bpd_top_tb.sv
// testbench for the bus port decoder
`timescale 1ns/1ps
module bpd_top_tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] base_sw = 8'h00;
  logic [3:0] irq_route = 4'hF;
  logic wait_en = 1'h0;
  logic [1:0] cpu_speed = 2'h0;
  logic irq_in = 1'h0;
  logic [7:0] addr, vi_req;
  logic sinp, sout, cyc, int_req, port_sel, fdc_sel, rdy_hold;
  logic [2:0] port_ofs;
  int fail_count = 0;
  int tests_run = 0;
  int w;
  always #12.5 clk = ~clk;
  bpd_top i_bpd_top (.CLK_SYS(clk), .RST(rst), .ADDR(addr), .SINP(sinp), .SOUT(sout),
    .CYCLE_ACTIVE(cyc), .BASE_SW(base_sw), .IRQ_ROUTE(irq_route), .WAIT_EN(wait_en),
    .CPU_SPEED(cpu_speed), .IRQ_IN(irq_in), .VI_REQ(vi_req), .INT_REQ(int_req),
    .PORT_SEL(port_sel), .PORT_OFS(port_ofs), .FDC_SEL(fdc_sel), .RDY_HOLD(rdy_hold));
  bpd_cpu_model i_bpd_cpu_model (.clk(clk), .rdy(rdy_hold), .addr(addr), .sinp(sinp),
    .sout(sout), .cyc(cyc));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  // low switch bits set on purpose: they must not move the block
  task automatic test_decode;
    logic [7:0] bases [3] = '{8'h00, 8'hE7, 8'hF8};
    for (int b = 0; b < 3; b++) begin
      base_sw = bases[b];
      for (int o = 0; o < 8; o++) begin
        i_bpd_cpu_model.io({bases[b][7:3], o[2:0]}, o[0], 1'h1, w);
        check("port_sel", port_sel, o < 6);
        check("port_ofs", port_ofs, o < 6 ? o : 0);
        check("fdc_sel", fdc_sel, o < 4);
      end
      i_bpd_cpu_model.io({bases[b][7:3] ^ 5'h01, 3'h0}, 1'h0, 1'h1, w);
      check("port_sel_other", port_sel, 8'h00);
      i_bpd_cpu_model.io({bases[b][7:3], 3'h1}, 1'h0, 1'h0, w);
      check("port_sel_memory", port_sel, 8'h00);
    end
  endtask : test_decode
  task automatic test_irq;
    for (int r = 0; r < 10; r++) begin
      irq_route = (r == 9) ? 4'hF : r[3:0];
      irq_in = 1'h1;
      repeat (2) @(negedge clk);
      check("vi_req", vi_req, r < 8 ? 8'h01 << r : 8'h00);
      check("int_req", int_req, r == 8);
      irq_in = 1'h0;
      repeat (2) @(negedge clk);
      check("vi_req_idle", vi_req, 8'h00);
      check("int_req_idle", int_req, 8'h00);
    end
  endtask : test_irq
  // back-to-back chip accesses, each rearmed by the cycle end
  task automatic test_wait;
    wait_en = 1'h1;
    for (int s = 0; s < 4; s++) begin
      cpu_speed = s[1:0];
      i_bpd_cpu_model.io({base_sw[7:3], 3'h3}, 1'h1, 1'h1, w);
      // the first cycle of the access waits on top of the base count
      check("wait_count", w, bpd_pkg::WAIT_CYC + 1 + 2 * s);
    end
    i_bpd_cpu_model.io({base_sw[7:3], 3'h4}, 1'h0, 1'h1, w);
    check("wait_other_port", w, 0);
    wait_en = 1'h0;
    i_bpd_cpu_model.io({base_sw[7:3], 3'h0}, 1'h0, 1'h1, w);
    check("wait_disabled", w, 0);
  endtask : test_wait
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'h0;
    test_decode();
    test_irq();
    test_wait();
    stop_test();
  end
  initial begin
    #(25 * 5000);
    fail_count++;
    stop_test();
  end
endmodule : bpd_top_tb
